// ### hw/lsc_defines.vh
// Purpose: constants for the line shading correction stage
// Assumes: 32-bit classic Wishbone register access, byte addresses
// Notes: definitions only
`ifndef LSC_DEFINES_VH
`define LSC_DEFINES_VH

// register byte offsets
`define LSC_ADR_CTRL 4'h0
`define LSC_ADR_CMD 4'h4
`define LSC_ADR_DATA 4'h8
`define LSC_ADR_STAT 4'hc

// control fields
`define LSC_CTRL_CORR_EN 0
`define LSC_CTRL_MODE10 1
`define LSC_CTRL_PERM 2
`define LSC_CTRL_WIDE 3
`define LSC_CTRL_RESET 4'h0

// command fields, write-only pulses
`define LSC_CMD_OPEN 0
`define LSC_CMD_CLOSE 1
`define LSC_CMD_COPY 2

// status fields
`define LSC_STAT_OPEN 0
`define LSC_STAT_COPY 1
`define LSC_STAT_ACTIVE 2
`define LSC_STAT_PTR_LSB 16

// table geometry and arithmetic
`define LSC_PIX_NARROW 12'h400
`define LSC_PIX_WIDE 12'h800
`define LSC_GAIN_ONE 9'h100
`define LSC_PIX_MAX 8'hff
`define LSC_FIFO_DEPTH 8

`endif

// ### hw/lsc_fifo.v
// Purpose: small synchronous fifo between the correction stage and the grabber link
// Assumes: single clock, valid/ready on both sides
// Notes: in_ready, out_valid and out_data are registered; depth must be a power of two
`timescale 1ns/1ps
module lsc_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rst_b,
  input wire in_valid,
  output reg in_ready,
  input wire [WIDTH-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;
  wire [AW:0] count_nxt;
  wire [AW-1:0] rd_nxt;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign rd_nxt = rd_ptr_r + {{(AW-1){1'b0}}, pop};

  // the head word is registered; a word pushed into the slot about to be read bypasses the memory
  always @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
    if (push & (wr_ptr_r == rd_nxt)) begin
      out_data <= in_data;
    end else begin
      out_data <= mem_r[rd_nxt];
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      count_r <= count_nxt;
      // full and empty are honest for the next cycle
      in_ready <= (count_nxt != DEPTH[AW:0]);
      out_valid <= (count_nxt != {(AW+1){1'b0}});
    end
  end
endmodule // lsc_fifo

// ### hw/lsc_top.v
// Purpose: per-pixel gain correction of captured lines with a loadable table
// Assumes: pixel stream on the same clock as the bus; one pixel per accepted cycle
// Notes: the retained table is not cleared by reset, standing in for non-volatile storage
`timescale 1ns/1ps
`include "lsc_defines.vh"
module lsc_top #(
  parameter ENTRIES = 2048,
  parameter IW = 11,
  parameter PW = 10
) (
  input wire clk,
  input wire rst_b,
  input wire wb_cyc,
  input wire wb_stb,
  input wire wb_we,
  input wire [3:0] wb_adr,
  input wire [3:0] wb_sel,
  input wire [31:0] wb_dat_w,
  output reg [31:0] wb_dat_r,
  output reg wb_ack,
  input wire pix_sol,
  input wire pix_valid,
  input wire [PW-1:0] pix_data,
  output wire pix_ready,
  output wire out_valid,
  input wire out_ready,
  output wire [PW-1:0] out_data
);
  // tables: working (reset-free volatile) and retained (never cleared)
  reg [7:0] work_tab [0:ENTRIES-1];
  reg [7:0] keep_tab [0:ENTRIES-1];

  // copy engine states, one-hot; bit 0 set means idle
  localparam CP_IDLE = 3'h1;
  localparam CP_RUN = 3'h2;
  localparam CP_DRAIN = 3'h4;

  reg [3:0] ctrl_r;
  reg open_r;
  reg [IW:0] up_ptr_r;
  reg [2:0] cp_state_r;
  reg [2:0] cp_state_nxt;
  reg [IW:0] copy_ptr_r;
  reg [IW:0] copy_ptr_nxt;
  reg copy_rd_ok_r;
  reg [IW-1:0] copy_wr_idx_r;
  reg [7:0] copy_dat_r;
  reg [IW-1:0] pix_idx_r;
  reg [7:0] coef_r;
  reg [PW-1:0] hold_pix_r;
  reg hold_valid_r;
  reg hold_corr_r;

  wire bus_req;
  wire wr_hit;
  wire [IW:0] tab_len;
  wire corr_on;
  wire fifo_in_ready;
  wire accept;
  wire [IW-1:0] rd_idx;
  wire data_wr;
  wire ctrl_wr;
  wire cmd_wr;
  wire cmd_open;
  wire cmd_close;
  wire cmd_copy;
  wire copy_busy;
  wire [31:0] stat_word;
  wire [16:0] product;
  wire [8:0] scaled;
  reg [PW-1:0] corr_pix;

  // a held strobe is taken once: the ack itself blocks a second take
  assign bus_req = wb_cyc & wb_stb & ~wb_ack;
  assign wr_hit = bus_req & wb_we & wb_sel[0];
  // width is read at access time, so changing it mid-upload moves the end point
  assign tab_len = ctrl_r[`LSC_CTRL_WIDE] ? `LSC_PIX_WIDE : `LSC_PIX_NARROW;
  // 10-bit mode forces correction off whatever the enable says
  assign corr_on = ctrl_r[`LSC_CTRL_CORR_EN] & ~ctrl_r[`LSC_CTRL_MODE10];
  // writes past the table end are dropped so a long upload cannot wrap onto entry 0
  assign data_wr = wr_hit & (wb_adr == `LSC_ADR_DATA) & open_r & (up_ptr_r < tab_len);
  assign ctrl_wr = wr_hit & (wb_adr == `LSC_ADR_CTRL);
  assign cmd_wr = wr_hit & (wb_adr == `LSC_ADR_CMD);
  assign cmd_open = cmd_wr & wb_dat_w[`LSC_CMD_OPEN];
  assign cmd_close = cmd_wr & wb_dat_w[`LSC_CMD_CLOSE];
  assign cmd_copy = cmd_wr & wb_dat_w[`LSC_CMD_COPY];
  assign copy_busy = ~cp_state_r[0];
  // the pointer field sits at bit 16 and up
  assign stat_word = {{(16-IW-1){1'b0}}, up_ptr_r, 13'h0000, corr_on, copy_busy, open_r};

  // register slave: ack one cycle after the request, dropped the cycle after
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack <= 1'b0;
      wb_dat_r <= 32'h0000_0000;
    end else begin
      wb_ack <= bus_req;
      wb_dat_r <= 32'h0000_0000;
      if (bus_req & ~wb_we) begin
        case (wb_adr)
          `LSC_ADR_CTRL: begin
            wb_dat_r <= {28'h000_0000, ctrl_r};
          end
          `LSC_ADR_STAT: begin
            wb_dat_r <= stat_word;
          end
          `LSC_ADR_CMD: begin
            // command bits are pulses, nothing to read back
            wb_dat_r <= 32'h0000_0000;
          end
          `LSC_ADR_DATA: begin
            // table values are not readable over the bus
            wb_dat_r <= 32'h0000_0000;
          end
          default: begin
            wb_dat_r <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= `LSC_CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_r <= wb_dat_w[3:0];
    end
  end

  // upload window: open resets the pointer, each data write appends one value
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      open_r <= 1'b0;
      up_ptr_r <= {(IW+1){1'b0}};
    end else begin
      if (cmd_open & ~copy_busy) begin
        open_r <= 1'b1;
        up_ptr_r <= {(IW+1){1'b0}};
      end else if (cmd_close) begin
        open_r <= 1'b0;
      end else if (data_wr) begin
        // packets just continue where the last left off
        up_ptr_r <= up_ptr_r + {{IW{1'b0}}, 1'b1};
      end
    end
  end

  // copy engine: one entry per cycle, retained to working
  always @* begin
    cp_state_nxt = cp_state_r;
    copy_ptr_nxt = copy_ptr_r;
    case (cp_state_r)
      CP_IDLE: begin
        // refused while an upload window is open or being opened by the same write
        if (cmd_copy & ~open_r & ~cmd_open) begin
          cp_state_nxt = CP_RUN;
          copy_ptr_nxt = {(IW+1){1'b0}};
        end
      end
      CP_RUN: begin
        if (copy_ptr_r < tab_len) begin
          copy_ptr_nxt = copy_ptr_r + {{IW{1'b0}}, 1'b1};
        end else begin
          cp_state_nxt = CP_DRAIN;
        end
      end
      CP_DRAIN: begin
        // the last retained read must reach the working table first
        if (~copy_rd_ok_r) begin
          cp_state_nxt = CP_IDLE;
        end
      end
      default: begin
        cp_state_nxt = CP_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cp_state_r <= CP_IDLE;
      copy_ptr_r <= {(IW+1){1'b0}};
      copy_rd_ok_r <= 1'b0;
      copy_wr_idx_r <= {IW{1'b0}};
    end else begin
      cp_state_r <= cp_state_nxt;
      copy_ptr_r <= copy_ptr_nxt;
      // the retained read lags the pointer by a cycle, so the write index trails it
      copy_rd_ok_r <= copy_busy & (copy_ptr_r < tab_len);
      copy_wr_idx_r <= copy_ptr_r[IW-1:0];
    end
  end

  // retained table: no reset, written only by permanent uploads
  always @(posedge clk) begin
    if (data_wr & ctrl_r[`LSC_CTRL_PERM]) begin
      keep_tab[up_ptr_r[IW-1:0]] <= wb_dat_w[7:0];
    end
    copy_dat_r <= keep_tab[copy_ptr_r[IW-1:0]];
  end

  // working table: every upload writes here, plus the copy engine
  always @(posedge clk) begin
    if (data_wr) begin
      work_tab[up_ptr_r[IW-1:0]] <= wb_dat_w[7:0];
    end else if (copy_rd_ok_r) begin
      work_tab[copy_wr_idx_r] <= copy_dat_r;
    end
  end

  // pixel path: index restarts on the first pixel of a line
  assign accept = pix_valid & fifo_in_ready;
  assign pix_ready = fifo_in_ready;
  // start of line forces entry 0 even mid-line, so a short line resyncs at once
  assign rd_idx = pix_sol ? {IW{1'b0}} : pix_idx_r;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pix_idx_r <= {IW{1'b0}};
    end else if (accept) begin
      // pixels past the table end reuse the last entry rather than wrapping
      if ({1'b0, rd_idx} < tab_len - {{IW{1'b0}}, 1'b1}) begin
        pix_idx_r <= rd_idx + {{(IW-1){1'b0}}, 1'b1};
      end else begin
        pix_idx_r <= rd_idx;
      end
    end
  end

  always @(posedge clk) begin
    if (accept) begin
      coef_r <= work_tab[rd_idx];
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_pix_r <= {PW{1'b0}};
      hold_valid_r <= 1'b0;
      hold_corr_r <= 1'b0;
    end else if (fifo_in_ready) begin
      // the mode rides with the pixel, so a control write lands on a pixel boundary
      hold_valid_r <= pix_valid;
      hold_pix_r <= pix_data;
      hold_corr_r <= corr_on;
    end
  end

  // (V+256)/256 as p + p*V/256, truncated by dropping the low byte
  // the factor stays below 2, so a shading ratio above 2/1 is only partly corrected
  assign product = {1'b0, hold_pix_r[7:0]} * ({1'b0, coef_r} + `LSC_GAIN_ONE);
  assign scaled = product[16:8];

  always @* begin
    corr_pix = hold_pix_r;
    if (hold_corr_r) begin
      if (scaled[8]) begin
        corr_pix = {{(PW-8){1'b0}}, `LSC_PIX_MAX};
      end else begin
        corr_pix = {{(PW-8){1'b0}}, scaled[7:0]};
      end
    end
  end

  // eight words ride out short grabber stalls; longer ones back up into pix_ready
  lsc_fifo #(
    .WIDTH(PW),
    .DEPTH(`LSC_FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(hold_valid_r),
    .in_ready(fifo_in_ready),
    .in_data(corr_pix),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );
endmodule // lsc_top

// ### verification/lsc_grabber.sv
// Purpose: frame grabber model taking corrected pixels
// Assumes: one pixel per cycle while ready
// Notes: stall holds ready low so the fifo backs up
`timescale 1ns/1ps
module lsc_grabber (
  input wire clk,
  input wire rst_b,
  input wire stall,
  input wire out_valid,
  input wire [9:0] out_data,
  output logic out_ready
);
  logic [9:0] got[$];
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= !stall;
      if (out_valid && out_ready) got.push_back(out_data);
    end
  end
endmodule // lsc_grabber

// ### verification/lsc_top_sva.sv
// Purpose: port checks for the shading stage
// Assumes: ctrl is written only while no pixel is in flight
// Notes: ctrl shadow is rebuilt from bus writes
`timescale 1ns/1ps
module lsc_top_sva #(
  parameter PW = 10
) (
  input wire clk,
  input wire rst_b,
  input wire wb_cyc,
  input wire wb_stb,
  input wire wb_we,
  input wire [3:0] wb_adr,
  input wire [3:0] wb_sel,
  input wire [31:0] wb_dat_w,
  input wire [31:0] wb_dat_r,
  input wire wb_ack,
  input wire pix_valid,
  input wire pix_ready,
  input wire out_valid,
  input wire out_ready,
  input wire [PW-1:0] out_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [3:0] ctl_r;
  logic [7:0] occ_r;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_r <= 4'h0;
      occ_r <= 8'h00;
    end else begin
      if (wb_cyc && wb_stb && !wb_ack && wb_we && wb_adr == 4'h0 && wb_sel[0])
        ctl_r <= wb_dat_w[3:0];
      occ_r <= occ_r + 8'(pix_valid && pix_ready) - 8'(out_valid && out_ready);
    end
  end
  sequence s_req;
    wb_cyc && wb_stb && !wb_ack;
  endsequence
  property p_ack; s_req |=> wb_ack; endproperty
  property p_pulse; wb_ack |=> !wb_ack; endproperty
  property p_rd0; !wb_ack |-> wb_dat_r == 32'h0000_0000; endproperty
  property p_orig; wb_ack |-> $past(wb_cyc && wb_stb); endproperty
  property p_ctl; wb_ack && $past(!wb_we && wb_adr == 4'h0) |-> wb_dat_r[3:0] == ctl_r; endproperty
  property p_unm; wb_ack && $past(wb_adr[1:0] != 2'b00) |-> wb_dat_r == 32'h0000_0000; endproperty
  property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_data); endproperty
  property p_src; out_valid |-> occ_r != 8'h00; endproperty
  property p_sat; out_valid && ctl_r[0] && !ctl_r[1] |-> out_data[PW-1:8] == 0; endproperty
  a_ack: assert property (p_ack) else $error("request not acked");
  a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
  a_rd0: assert property (p_rd0) else $error("read data without ack");
  a_orig: assert property (p_orig) else $error("ack without request");
  a_ctl: assert property (p_ctl) else $error("ctrl readback wrong");
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  a_hold: assert property (p_hold) else $error("output changed while stalled");
  a_src: assert property (p_src) else $error("output with no pixel taken");
  a_sat: assert property (p_sat) else $error("corrected pixel above 255");
endmodule // lsc_top_sva
bind lsc_top lsc_top_sva #(.PW(PW)) u_sva (.clk, .rst_b, .wb_cyc, .wb_stb, .wb_we, .wb_adr,
  .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .pix_valid, .pix_ready, .out_valid, .out_ready,
  .out_data);

// ### verification/lsc_top_test.sv
// Purpose: register and pixel path tests of the shading stage
// Assumes: narrow 1024 entry table, one pixel per cycle
// Notes: tables are i*k mod 256 so expectations follow from k
`timescale 1ns/1ps
`include "lsc_defines.vh"
module lsc_top_test;
  logic clk = 0, rst_b = 0, wb_cyc = 0, wb_stb = 0, wb_we = 0, pix_sol = 0, pix_valid = 0;
  logic stall = 0, wb_ack, pix_ready, out_valid, out_ready;
  logic [3:0] wb_adr = 4'h0;
  logic [31:0] wb_dat_w = 32'h0000_0000, wb_dat_r, q;
  logic [9:0] pix_data = 10'h000, out_data;
  int n_mismatch = 0, tests_run = 0, kw = 0;
  always #5 clk = ~clk;
  lsc_top DUT (.clk, .rst_b, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel(4'h1), .wb_dat_w,
    .wb_dat_r, .wb_ack, .pix_sol, .pix_valid, .pix_data, .pix_ready, .out_valid, .out_ready,
    .out_data);
  lsc_grabber g (.clk, .rst_b, .stall, .out_valid, .out_data, .out_ready);
  task chk(input string s, input logic [31:0] e, input logic [31:0] v);
    tests_run++;
    if (v !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", s, e, v);
    end
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat_w <= d;
    @(posedge clk iff wb_ack);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk);
  endtask
  task up(input logic [31:0] c, input int k);
    wb(1'b1, `LSC_ADR_CTRL, c);
    wb(1'b1, `LSC_ADR_CMD, 32'h0000_0001);
    for (int i = 0; i < 1024; i++) wb(1'b1, `LSC_ADR_DATA, 32'((i * k) & 255));
    wb(1'b0, `LSC_ADR_STAT, 32'h0000_0000);
    chk("ptr", 32'h0000_0400, {20'h0_0000, q[27:16]});
    wb(1'b1, `LSC_ADR_CMD, 32'h0000_0002);
    kw = k;
    $display("test upload %0d done", k);
  endtask
  // m: 0 correction off, 1 corrected, 2 ten-bit passthrough, 3 uniform gray
  task line(input int m, input logic [31:0] c);
    logic [9:0] p;
    int e;
    logic [9:0] ex[$];
    ex.delete();
    wb(1'b1, `LSC_ADR_CTRL, c);
    for (int i = 0; i < 20; i++) begin
      p = m == 2 ? 10'(700 + i * 13) : m == 3 ? 10'h080 : 10'(60 + i * 10);
      e = m == 1 ? (p * (((i * kw) & 255) + 256)) >> 8 : p;
      ex.push_back(e > 255 && m == 1 ? 10'h0ff : 10'(e));
      pix_valid <= 1'b1;
      pix_sol <= i == 0;
      pix_data <= p;
      @(posedge clk iff pix_ready);
    end
    pix_valid <= 1'b0;
    pix_sol <= 1'b0;
    repeat (300) if (g.got.size() < 20) @(posedge clk);
    for (int i = 0; i < 20; i++) chk("pixel", 32'(ex[i]), 32'(g.got[i]));
    g.got.delete();
    $display("test line %0d done", m);
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    complete_run;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    wb(1'b0, `LSC_ADR_CTRL, 32'h0000_0000);
    chk("ctrl", 32'h0000_0000, q);
    wb(1'b0, `LSC_ADR_STAT, 32'h0000_0000);
    chk("stat", 32'h0000_0000, q);
    wb(1'b0, 4'h2, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, q);
    repeat (100) line(3, 32'h0000_0000);
    up(32'h0000_0004, 37);
    fork
      line(1, 32'h0000_0001);
      begin
        stall <= 1'b1;
        repeat (40) @(posedge clk);
        stall <= 1'b0;
      end
    join
    line(0, 32'h0000_0000);
    line(2, 32'h0000_0003);
    up(32'h0000_0000, 0);
    line(1, 32'h0000_0001);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    wb(1'b1, `LSC_ADR_CMD, 32'h0000_0004);
    repeat (1000) begin
      wb(1'b0, `LSC_ADR_STAT, 32'h0000_0000);
      if (!q[1]) break;
    end
    chk("copy", 32'h0000_0000, q & 32'h0000_0002);
    kw = 37;
    line(1, 32'h0000_0001);
    complete_run;
  end
endmodule // lsc_top_test
